/* File: gpt_defines.svh */
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

// ==========================================================
// register map (word index on the plain register port)
`define GPT_ADDR_W 3
`define GPT_REG_CONTROL 3'h0
`define GPT_REG_PERIOD 3'h1
`define GPT_REG_COUNT 3'h2
`define GPT_REG_STATUS 3'h3
`define GPT_REG_MASK 3'h4
`define GPT_REG_IRQ_CFG 3'h5

// ==========================================================
// control register fields
`define GPT_BIT_RUN 15
`define GPT_BIT_IDLE_HALT 13
`define GPT_BIT_GATE 6
`define GPT_BIT_PS_HI 5
`define GPT_BIT_PS_LO 4
`define GPT_BIT_SYNC 2
`define GPT_BIT_SRC 1
`define GPT_CONTROL_MASK 16'ha076
`define GPT_CONTROL_RESET 16'h0000
`define GPT_PERIOD_RESET 16'hffff

// ==========================================================
// status / mask bits and irq config fields
`define GPT_ST_MATCH 0
`define GPT_ST_GATE_FALL 1
`define GPT_ST_W 2
`define GPT_CFG_EN 3
`define GPT_CFG_PRIO_HI 2
`define GPT_CFG_PRIO_LO 0

// ==========================================================
// prescale codes and their divide terminal counts
`define GPT_PS_1 2'h0
`define GPT_PS_8 2'h1
`define GPT_PS_64 2'h2
`define GPT_PS_256 2'h3
`define GPT_DIV_8_LAST 8'h07
`define GPT_DIV_64_LAST 8'h3f
`define GPT_DIV_256_LAST 8'hff

`endif

/* File: gpt_pkg.sv */
package gpt_pkg;

   // ==========================================================
   // control register image, bit 15 down to bit 0
   typedef struct packed {
      logic run;
      logic rsv14;
      logic idle_halt;
      logic [5:0] rsv12_7;
      logic gate_accumulate_en;
      logic [1:0] prescale_select;
      logic rsv3;
      logic ext_clock_sync;
      logic clock_source_sel;
      logic rsv0;
   } gpt_control_t;

   // register port request grouped together
   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } gpt_bus_req_t;

   // interrupt request with its priority
   typedef struct packed {
      logic req;
      logic [2:0] priority_level;
   } gpt_irq_t;

endpackage

/* File: gpt_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defines.svh"

// two-flop synchroniser plus a third stage for edge detection
module gpt_edge_sync
   import gpt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);

   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } gpt_sync_state_t;

   gpt_sync_state_t state;
   gpt_sync_state_t next_state;

   // ==========================================================
   // shift chain; only sync and last feed any logic
   always_comb begin
      next_state = state;
      next_state.meta = pin;
      next_state.sync = state.meta;
      next_state.last = state.sync;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign level = state.sync;
   assign rise = state.sync & ~state.last;
   assign fall = ~state.sync & state.last;

endmodule
`default_nettype wire

/* File: gpt_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defines.svh"

// divides a tick stream by 1, 8, 64 or 256
module gpt_prescaler
   import gpt_pkg::*;
#(
   parameter int DIV_W = 8
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clear,
   input wire logic tick_in,
   input wire logic [1:0] prescale_select,
   output logic tick_out
);

   typedef struct packed {
      logic [DIV_W-1:0] count;
   } gpt_ps_state_t;

   gpt_ps_state_t state;
   gpt_ps_state_t next_state;
   logic [DIV_W-1:0] last;

   // ==========================================================
   // terminal count for the selected ratio
   always_comb begin
      unique case (prescale_select)
         `GPT_PS_1: last = '0;
         `GPT_PS_8: last = DIV_W'(`GPT_DIV_8_LAST);
         `GPT_PS_64: last = DIV_W'(`GPT_DIV_64_LAST);
         `GPT_PS_256: last = DIV_W'(`GPT_DIV_256_LAST);
      endcase
   end

   // output tick is combinational so ratio 1 adds no latency
   assign tick_out = tick_in & (state.count >= last) & ~clear;

   always_comb begin
      next_state = state;
      if (clear) begin
         next_state.count = '0;
      end else if (tick_in) begin
         if (state.count >= last) begin
            next_state.count = '0;
         end else begin
            next_state.count = state.count + DIV_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

endmodule
`default_nettype wire

/* File: gpt_timer.sv */
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defines.svh"

// What this block does
// R1: 16-bit timer: internal clock, synced or raw external edges.
// R2: interrupt on period match, or on gate falling edge in gated mode.
// R3: control bit 15 runs the timer when one, stops it when zero.
// R4: idle-halt bit one freezes the timer while the system idles.
// R5: gate enable ignored when the external clock is selected.
// R6: internal clock with gate enable counts only while the gate allows.
// R7: prescale codes 11, 10, 01, 00 divide by 256, 64, 8, 1.
// R8: sync bit chooses synchronised external clock; ignored on internal clock.
// R9: source bit one counts pin rising edges; zero counts half-rate clock.
// R10: control bits 14, 12-7, 3 and 0 ignore writes, read zero.
// R11: writing control while running resets the prescale counter.
// R12: software sets control and period before relying on match interrupts.
// R13: serves as real-time clock base or free-running timer or counter.
// R14: keeps running in idle and sleep unless idle-halt is set.
// R15: interrupt forwarded only when enabled; carries a three-bit priority.
// R16: count steps per tick; at period it wraps to zero and flags; the match flag is set one tick after the wrap.
// R17: gated mode counts prescaled internal ticks only while gate is high.
// R18: reset clears control: stopped, internal clock, no prescale, gate, sync.
module gpt_timer
   import gpt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [2:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic ext_count_pin,
   input wire logic system_idle,
   output logic timer_irq,
   output logic [2:0] timer_irq_priority,
   output logic rtc_tick
);

   // ==========================================================
   // state
   typedef struct packed {
      gpt_control_t control;
      logic [15:0] period_value;
      logic [15:0] count;
      logic [`GPT_ST_W-1:0] status;
      logic [`GPT_ST_W-1:0] mask;
      logic timer_irq_enable;
      logic [2:0] timer_irq_priority;
      logic half_phase;
      logic raw_last;
      logic match_pending;
      logic [15:0] rdata;
      logic irq;
      logic rtc_tick;
   } gpt_state_t;

   gpt_state_t state;
   gpt_state_t next_state;
   gpt_bus_req_t req;

   logic pin_level;
   logic pin_rise;
   logic pin_fall;
   logic ps_clear;
   logic ps_tick_in;
   logic ps_tick;
   logic running;
   logic gated;
   logic raw_rise;
   logic ctrl_wr;
   logic [15:0] ctrl_image;
   logic [`GPT_ST_W-1:0] events;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr,
                  rd: reg_rd};

   // ==========================================================
   // external pin conditioning
   gpt_edge_sync u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin(ext_count_pin),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // unsynchronised mode: edge seen straight off the pin, one flop
   // of history only; saves two cycles of latency at metastability risk
   assign raw_rise = ext_count_pin & ~state.raw_last; // [R8]

   // ==========================================================
   // tick source selection
   assign ctrl_wr = req.wr && (req.addr == `GPT_REG_CONTROL);
   // idle freezes the timer only with idle-halt set; sleep has no effect
   assign running = state.control.run & // [R3] [R14]
                    ~(state.control.idle_halt & system_idle); // [R4]
   // gate enable only honoured on the internal clock
   assign gated = state.control.gate_accumulate_en &
                  ~state.control.clock_source_sel; // [R5]

   always_comb begin
      if (state.control.clock_source_sel) begin // [R9]
         ps_tick_in = state.control.ext_clock_sync ? pin_rise
                                                   : raw_rise; // [R8]
      end else if (gated) begin
         ps_tick_in = state.half_phase & pin_level; // [R6] [R17]
      end else begin
         ps_tick_in = state.half_phase; // [R9]
      end
      ps_tick_in = ps_tick_in & running;
   end

   // any control write while running clears the prescale counter
   assign ps_clear = ctrl_wr & state.control.run; // [R11]

   gpt_prescaler #(
      .DIV_W(8)
   ) u_ps (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(ps_clear),
      .tick_in(ps_tick_in),
      .prescale_select(state.control.prescale_select), // [R7]
      .tick_out(ps_tick)
   );

   // ==========================================================
   // interrupt sources
   always_comb begin
      events = '0;
      // match fires on the tick after count equalled period
      events[`GPT_ST_MATCH] = ps_tick & state.match_pending &
                              ~gated; // [R16] [R2]
      // gated mode flags on gate falling edge instead of a match
      events[`GPT_ST_GATE_FALL] = gated & running & pin_fall; // [R2]
   end

   assign ctrl_image = req.wdata & `GPT_CONTROL_MASK; // [R10]

   // ==========================================================
   // next state
   always_comb begin
      next_state = state;
      next_state.half_phase = ~state.half_phase;
      next_state.raw_last = ext_count_pin;
      next_state.rtc_tick = 1'b0;
      // count update
      if (ps_tick) begin
         if (state.count == state.period_value) begin
            next_state.count = '0; // [R16]
            next_state.match_pending = 1'b1;
         end else begin
            next_state.count = state.count + 16'h0001; // [R1] [R16]
            next_state.match_pending = 1'b0;
         end
         // wrap pulse serves as a real-time clock time base
         next_state.rtc_tick = state.match_pending; // [R13]
      end
      // register writes
      if (req.wr) begin
         unique case (req.addr)
            `GPT_REG_CONTROL: next_state.control = ctrl_image; // [R3]
            `GPT_REG_PERIOD: next_state.period_value = req.wdata; // [R12]
            `GPT_REG_COUNT: begin
               next_state.count = req.wdata;
               next_state.match_pending = 1'b0;
            end
            `GPT_REG_STATUS: next_state.status =
               state.status & ~req.wdata[`GPT_ST_W-1:0];
            `GPT_REG_MASK: next_state.mask = req.wdata[`GPT_ST_W-1:0];
            `GPT_REG_IRQ_CFG: begin
               next_state.timer_irq_enable = req.wdata[`GPT_CFG_EN];
               next_state.timer_irq_priority =
                  req.wdata[`GPT_CFG_PRIO_HI:`GPT_CFG_PRIO_LO];
            end
            default: ;
         endcase
      end
      // a new event wins over a same-cycle write-one clear
      next_state.status = next_state.status | events;
      // reads answer one cycle later; unmapped reads return zero
      next_state.rdata = '0;
      if (req.rd) begin
         unique case (req.addr)
            `GPT_REG_CONTROL: next_state.rdata = state.control; // [R10]
            `GPT_REG_PERIOD: next_state.rdata = state.period_value;
            `GPT_REG_COUNT: next_state.rdata = state.count;
            `GPT_REG_STATUS: next_state.rdata = 16'(state.status);
            `GPT_REG_MASK: next_state.rdata = 16'(state.mask);
            `GPT_REG_IRQ_CFG: next_state.rdata =
               {12'h000, state.timer_irq_enable, state.timer_irq_priority};
            default: next_state.rdata = '0;
         endcase
      end
      // level irq from the next-cycle status and mask, gated by enable
      next_state.irq = state.timer_irq_enable &
                       (|(next_state.status & next_state.mask)); // [R15]
   end

   // ==========================================================
   // registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= '0;
         state.control <= `GPT_CONTROL_RESET; // [R18]
         state.period_value <= `GPT_PERIOD_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata = state.rdata;
   assign timer_irq = state.irq;
   assign timer_irq_priority = state.timer_irq_priority; // [R15]
   assign rtc_tick = state.rtc_tick;

endmodule
`default_nettype wire

/* File: gpt_timer_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defines.svh"

// ==========================================================
// port-level checks on the timer
module gpt_timer_monitor
   import gpt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [2:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic ext_count_pin,
   input wire logic system_idle,
   input wire logic timer_irq,
   input wire logic [2:0] timer_irq_priority,
   input wire logic rtc_tick
);
   logic [15:0] ctl_q;
   logic cfg_wr;
   logic irq_wr;

   // shadow of the control word, so reads can be predicted
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctl_q <= 16'h0000;
      end else if (reg_wr && reg_addr == `GPT_REG_CONTROL) begin
         ctl_q <= reg_wdata;
      end
   end

   // writes that may legally move the irq outputs
   assign cfg_wr = reg_wr && reg_addr == `GPT_REG_IRQ_CFG;
   assign irq_wr = reg_wr && reg_addr >= `GPT_REG_STATUS;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence ctl_read;
      reg_rd && reg_addr == `GPT_REG_CONTROL;
   endsequence
   sequence far_read;
      reg_rd && reg_addr > `GPT_REG_IRQ_CFG;
   endsequence

   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
      else $error("read data not zero outside a read");
   ctl_read_a: assert property (ctl_read |=>
      reg_rdata == (ctl_q & `GPT_CONTROL_MASK))
      else $error("control readback wrong");
   far_read_a: assert property (far_read |=> reg_rdata == 16'h0)
      else $error("unmapped read not zero");
   prio_change_a: assert property ($changed(timer_irq_priority) |->
      $past(cfg_wr) || $past(cfg_wr, 2))
      else $error("priority moved without a write");
   irq_fall_a: assert property ($fell(timer_irq) |->
      $past(irq_wr) || $past(irq_wr, 2))
      else $error("irq dropped without a write");
   tick_pulse_a: assert property (rtc_tick |=> !rtc_tick)
      else $error("time-base tick longer than one cycle");
   stop_quiet_a: assert property
      ((!ctl_q[`GPT_BIT_RUN]) [*4] |-> !rtc_tick)
      else $error("tick while stopped");
   idle_quiet_a: assert property
      ((ctl_q[`GPT_BIT_IDLE_HALT] && system_idle) [*4] |-> !rtc_tick)
      else $error("tick while halted in idle");
endmodule

bind gpt_timer gpt_timer_monitor u_mon (.ref_clk, .reset, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_count_pin, .system_idle,
   .timer_irq, .timer_irq_priority, .rtc_tick);
`default_nettype wire

/* File: gpt_pin_src.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// external count / gate source: bursts of pulses or a level
module gpt_pin_src
   import gpt_pkg::*;
#(
   parameter int HALF = 4
)
(
   input wire logic ref_clk,
   input wire logic start,
   input wire logic [7:0] pulses,
   input wire logic level,
   output logic pin,
   output logic busy
);
   logic [7:0] left = 8'h00;
   int cnt = 0;

   // slow half periods keep raw-pin edge detection honest
   always @(posedge ref_clk) begin
      if (start) begin
         left <= {pulses[6:0], 1'b0};
         cnt <= 0;
      end else if (left != 8'h00) begin
         cnt <= cnt + 1;
         if (cnt == HALF - 1) begin
            cnt <= 0;
            left <= left - 8'h01;
            pin <= ~pin;
         end
      end else begin
         pin <= level;
      end
   end
   assign busy = left != 8'h00;
endmodule
`default_nettype wire

/* File: gpt_timer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end

// ==========================================================
// register-level tests of the timer
module gpt_timer_bench;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic system_idle = 1'b0;
   logic src_start = 1'b0;
   logic [7:0] src_pulses = 8'h00;
   logic src_level = 1'b0;
   logic [15:0] reg_rdata;
   logic ext_count_pin;
   logic timer_irq;
   logic [2:0] timer_irq_priority;
   logic rtc_tick;
   logic src_busy;
   logic [15:0] v;
   logic [15:0] w;
   int num_errors = 0;
   int compares = 0;
   int n = 0;
   int div[4] = '{1, 8, 64, 256};

   always #20 ref_clk = ~ref_clk;

   gpt_timer u_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ext_count_pin(ext_count_pin),
      .system_idle(system_idle), .timer_irq(timer_irq),
      .timer_irq_priority(timer_irq_priority), .rtc_tick(rtc_tick));
   gpt_pin_src u_src (.ref_clk(ref_clk), .start(src_start),
      .pulses(src_pulses), .level(src_level), .pin(ext_count_pin),
      .busy(src_busy));

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rdchk(input logic [2:0] a, input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      `CHK(d, e)
   endtask
   task automatic pulse(input logic [7:0] n);
      int k;
      @(posedge ref_clk);
      src_pulses <= n;
      src_start <= 1'b1;
      @(posedge ref_clk);
      src_start <= 1'b0;
      #1 k = 0;
      while (src_busy && k < 500) begin
         @(posedge ref_clk);
         k++;
      end
   endtask
   task automatic complete_run;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // watchdog, well beyond the six thousand cycles the tests need
   initial begin
      cyc(30000);
      num_errors++;
      complete_run;
   end

   initial begin
      cyc(2);
      reset <= 1'b0;
      rdchk(0, 16'h0000);
      rdchk(1, 16'hffff);
      rdchk(2, 16'h0000);
      wr(0, 16'h7fff);
      rdchk(0, 16'h2076);
      rdchk(6, 16'h0000);
      $display("test registers done");
      for (int c = 0; c < 4; c++) begin
         wr(0, 16'h0000);
         wr(2, 16'h0000);
         wr(0, {10'h200, c[1:0], 4'h0});
         cyc(16 * div[c]);
         rd(2, v);
         `CHK(v >= 7 && v <= 9, 1'b1)
      end
      wr(0, 16'h0000);
      rd(2, v);
      cyc(40);
      rdchk(2, v);
      $display("test prescale done");
      wr(1, 16'h0003);
      wr(2, 16'h0000);
      wr(4, 16'h0001);
      wr(5, 16'h000d);
      wr(0, 16'h8000);
      cyc(30);
      #1;
      `CHK(timer_irq, 1'b1)
      `CHK(timer_irq_priority, 3'h5)
      // period 3 wraps every 4 ticks, 8 cycles: 4 pulses in 32
      n = 0;
      repeat (32) begin
         @(posedge ref_clk);
         #1;
         if (rtc_tick) n++;
      end
      `CHK(n, 4)
      rdchk(5, 16'h000d);
      rd(3, v);
      `CHK(v[0], 1'b1)
      wr(4, 16'h0000);
      cyc(3);
      #1;
      `CHK(timer_irq, 1'b0)
      wr(0, 16'h0000);
      rd(2, v);
      `CHK(v <= 3, 1'b1)
      wr(4, 16'h0001);
      cyc(3);
      #1;
      `CHK(timer_irq, 1'b1)
      wr(5, 16'h0005);
      cyc(3);
      #1;
      `CHK(timer_irq, 1'b0)
      wr(5, 16'h000d);
      wr(3, 16'h0003);
      cyc(3);
      #1;
      `CHK(timer_irq, 1'b0)
      rdchk(3, 16'h0000);
      $display("test interrupt done");
      // full period again, so later counts never wrap
      wr(1, 16'hffff);
      wr(2, 16'h0000);
      system_idle <= 1'b1;
      wr(0, 16'ha000);
      cyc(40);
      rdchk(2, 16'h0000);
      wr(0, 16'h8000);
      cyc(40);
      rd(2, v);
      `CHK(v >= 17 && v <= 22, 1'b1)
      @(posedge ref_clk);
      system_idle <= 1'b0;
      $display("test idle done");
      wr(0, 16'h0000);
      wr(2, 16'h0000);
      wr(0, 16'h8046);
      pulse(8'd5);
      cyc(5);
      rdchk(2, 16'h0005);
      wr(0, 16'h8042);
      pulse(8'd5);
      cyc(5);
      rdchk(2, 16'h000a);
      $display("test external done");
      wr(0, 16'h0000);
      wr(2, 16'h0000);
      wr(3, 16'h0003);
      wr(0, 16'h8040);
      src_level <= 1'b1;
      cyc(40);
      src_level <= 1'b0;
      cyc(10);
      rd(2, v);
      `CHK(v >= 17 && v <= 22, 1'b1)
      cyc(20);
      rdchk(2, v);
      rd(3, w);
      `CHK(w, 16'h0002)
      wr(4, 16'h0002);
      #1;
      `CHK(timer_irq, 1'b1)
      $display("test gated done");
      wr(0, 16'h8010);
      wr(2, 16'h0000);
      repeat (10) begin
         wr(0, 16'h8010);
         cyc(8);
      end
      rdchk(2, 16'h0000);
      wr(0, 16'h0000);
      $display("test prescale clear done");
      complete_run;
   end
endmodule
`default_nettype wire
